// ---- core/pmcr_pkg.sv ----
package pmcr_pkg;

    // ****************************************
    // bus-to-core ratio encodings
    // ****************************************
    typedef enum logic [1:0] {
        PMCR_RATIO_2_5 = 2'b00,
        PMCR_RATIO_1_2 = 2'b10,
        PMCR_RATIO_2_3 = 2'b11
    } pmcr_ratio_e;

    localparam logic [1:0] PMCR_RATIO_RST = 2'b11;
    // numerator and denominator of bus/core ratio
    localparam logic [3:0] PMCR_NUM_2_5 = 4'h2;
    localparam logic [3:0] PMCR_DEN_2_5 = 4'h5;
    localparam logic [3:0] PMCR_NUM_1_2 = 4'h1;
    localparam logic [3:0] PMCR_DEN_1_2 = 4'h2;
    localparam logic [3:0] PMCR_NUM_2_3 = 4'h2;
    localparam logic [3:0] PMCR_DEN_2_3 = 4'h3;

    // ****************************************
    // core states and bus cycle codes
    // ****************************************
    typedef enum logic [1:0] {
        PMCR_RUN   = 2'b00,
        PMCR_SMM   = 2'b01,
        PMCR_STOP  = 2'b10
    } pmcr_state_e;

    localparam logic [1:0] PMCR_CYC_NONE  = 2'b00;
    localparam logic [1:0] PMCR_CYC_GRANT = 2'b01;
    localparam logic [1:0] PMCR_CYC_SNOOP = 2'b10;

    typedef struct packed {
        logic [3:0] num;
        logic [3:0] den;
    } pmcr_ratio_s;

endpackage

// ---- core/pmcr_top.sv ----
`timescale 1ns/1ps
// Function
// RL1: latch system management interrupt request pulses
// RL2: enter management mode only at boundary
// RL3: active output low throughout management mode
// RL4: external logic asserts stop-clock request low
// RL5: stop at boundary unless higher interrupt
// RL6: issue stop-grant acknowledge bus cycle
// RL7: keep answering snoops while stop requested
// RL8: ratio select 00 2/5, 10 1/2, 11 2/3
// RL9: capture ratio select during reset, hold
// RL10: active output releases on mode exit
module pmcr_top
    import pmcr_pkg::*;
(
    input  wire logic       i_mclk,
    input  wire logic       i_rstn,
    input  wire logic       i_sys_mgmt_irq_n,
    input  wire logic       i_stop_clock_req_n,
    input  wire logic       i_bus_ratio_sel_hi,
    input  wire logic       i_bus_ratio_sel_lo,
    input  wire logic       i_insn_boundary,
    input  wire logic       i_hi_prio_irq,
    input  wire logic       i_sys_mgmt_resume,
    input  wire logic       i_snoop_req,
    output logic            o_sys_mgmt_active_n,
    output logic            o_core_halted,
    output logic            o_grant_cycle,
    output logic            o_snoop_ack,
    output logic [1:0]      o_bus_cycle,
    output pmcr_ratio_s     o_ratio,
    output logic [1:0]      o_ratio_sel
);

    // ****************************************
    // input synchronisers
    // ****************************************
    logic [1:0] smi_sync_reg;
    logic [1:0] stp_sync_reg;
    logic [1:0] bfh_sync_reg;
    logic [1:0] bfl_sync_reg;

    // request syncs reset to the idle-high level so no false request follows reset
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            smi_sync_reg <= 2'h3;
            stp_sync_reg <= 2'h3;
        end else begin
            smi_sync_reg <= {smi_sync_reg[0], i_sys_mgmt_irq_n};
            stp_sync_reg <= {stp_sync_reg[0], i_stop_clock_req_n};
        end
    end

    // strap syncs keep running through reset, so the settled straps are
    // already at the second flop when the capture window closes
    always_ff @(posedge i_mclk) begin
        bfh_sync_reg <= {bfh_sync_reg[0], i_bus_ratio_sel_hi};
        bfl_sync_reg <= {bfl_sync_reg[0], i_bus_ratio_sel_lo};
    end

    wire logic smi_req = ~smi_sync_reg[1];
    wire logic stp_req = ~stp_sync_reg[1]; // RL4

    function automatic pmcr_ratio_s ratio_of(input logic [1:0] sel);
        pmcr_ratio_s r;
        r = '{num: PMCR_NUM_2_3, den: PMCR_DEN_2_3};
        case (sel)
            PMCR_RATIO_2_5: r = '{num: PMCR_NUM_2_5, den: PMCR_DEN_2_5};
            PMCR_RATIO_1_2: r = '{num: PMCR_NUM_1_2, den: PMCR_DEN_1_2};
            default:        r = '{num: PMCR_NUM_2_3, den: PMCR_DEN_2_3};
        endcase
        return r;
    endfunction

    // ****************************************
    // ratio capture
    // ****************************************
    // reset is asynchronous, so the strap is sampled by clock while a
    // reset-window flag is still set, then frozen
    logic        strap_win_reg;
    logic        strap_win_next;
    logic [1:0]  sel_reg;
    logic [1:0]  sel_next;
    pmcr_ratio_s ratio_reg;
    pmcr_ratio_s ratio_next;

    always_comb begin
        strap_win_next = 1'b0;
        sel_next       = sel_reg;
        ratio_next     = ratio_reg;
        if (strap_win_reg) begin
            sel_next   = {bfh_sync_reg[1], bfl_sync_reg[1]}; // RL9
            // 01 is undefined; treated as the default ratio
            if (sel_next == 2'b01) begin
                sel_next = PMCR_RATIO_RST;
            end
            ratio_next = ratio_of(sel_next); // RL8
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            strap_win_reg <= 1'b1;
            sel_reg       <= PMCR_RATIO_RST;
            ratio_reg     <= '{num: PMCR_NUM_2_3, den: PMCR_DEN_2_3};
        end else begin
            strap_win_reg <= strap_win_next;
            sel_reg       <= sel_next;
            ratio_reg     <= ratio_next;
        end
    end

    // ****************************************
    // mode control
    // ****************************************
    pmcr_state_e state_reg;
    pmcr_state_e state_next;
    logic        smi_pend_reg;
    logic        smi_pend_next;
    logic        act_n_reg;
    logic        act_n_next;
    logic        grant_reg;
    logic        grant_next;
    logic        snoop_reg;
    logic        snoop_next;
    logic [1:0]  cyc_reg;
    logic [1:0]  cyc_next;

    always_comb begin
        state_next    = state_reg;
        smi_pend_next = smi_pend_reg | smi_req; // RL1
        grant_next    = 1'b0;
        snoop_next    = i_snoop_req; // RL7
        cyc_next      = i_snoop_req ? PMCR_CYC_SNOOP : PMCR_CYC_NONE;
        case (state_reg)
            PMCR_RUN: begin
                if (i_insn_boundary && smi_pend_reg) begin
                    state_next    = PMCR_SMM; // RL2
                    smi_pend_next = smi_req;
                end else if (i_insn_boundary && stp_req && !i_hi_prio_irq) begin
                    state_next = PMCR_STOP; // RL5
                    grant_next = 1'b1; // RL6
                    cyc_next   = PMCR_CYC_GRANT; // RL6
                end
            end
            PMCR_SMM: begin
                if (i_sys_mgmt_resume) begin
                    state_next = PMCR_RUN; // RL10
                end
            end
            PMCR_STOP: begin
                // a pending management request must wake the core
                if (!stp_req || smi_pend_reg) begin
                    state_next = PMCR_RUN;
                end
            end
            default: state_next = PMCR_RUN;
        endcase
        act_n_next = (state_next != PMCR_SMM); // RL3
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            state_reg    <= PMCR_RUN;
            smi_pend_reg <= 1'b0;
            act_n_reg    <= 1'b1;
            grant_reg    <= 1'b0;
            snoop_reg    <= 1'b0;
            cyc_reg      <= PMCR_CYC_NONE;
        end else begin
            state_reg    <= state_next;
            smi_pend_reg <= smi_pend_next;
            act_n_reg    <= act_n_next;
            grant_reg    <= grant_next;
            snoop_reg    <= snoop_next;
            cyc_reg      <= cyc_next;
        end
    end

    logic halted_reg;
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            halted_reg <= 1'b0;
        end else begin
            halted_reg <= (state_next == PMCR_STOP);
        end
    end

    assign o_sys_mgmt_active_n = act_n_reg;
    assign o_core_halted       = halted_reg;
    assign o_grant_cycle       = grant_reg;
    assign o_snoop_ack         = snoop_reg;
    assign o_bus_cycle         = cyc_reg;
    assign o_ratio             = ratio_reg;
    assign o_ratio_sel         = sel_reg;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);

    a_smi_latched: assert property (smi_req |=> smi_pend_reg || state_reg == PMCR_SMM) // RL1
        else $error("management request not latched");
    a_smm_at_bound: assert property ($rose(state_reg == PMCR_SMM)
        |-> $past(i_insn_boundary) && $past(smi_pend_reg)) // RL2
        else $error("management mode entered off boundary");
    a_active_tracks: assert property ((state_reg == PMCR_SMM) == !o_sys_mgmt_active_n) // RL3
        else $error("active output disagrees with mode");
    a_stop_bound: assert property ($rose(state_reg == PMCR_STOP)
        |-> $past(i_insn_boundary) && !$past(i_hi_prio_irq) && $past(stp_req)) // RL5
        else $error("stop taken at wrong time");
    a_grant_once: assert property ($rose(state_reg == PMCR_STOP)
        |-> o_grant_cycle && o_bus_cycle == PMCR_CYC_GRANT ##1 !o_grant_cycle) // RL6
        else $error("stop grant cycle not issued once");
    a_snoop_stop: assert property (state_reg == PMCR_STOP && i_snoop_req
        |=> o_snoop_ack && o_bus_cycle == PMCR_CYC_SNOOP) // RL7
        else $error("snoop ignored while stopped");
    a_ratio_map: assert property (!strap_win_reg && sel_reg == 2'b00
        |-> o_ratio.num == PMCR_NUM_2_5 && o_ratio.den == PMCR_DEN_2_5) // RL8
        else $error("ratio decode wrong");
    a_ratio_hold: assert property (!strap_win_reg |=> $stable(o_ratio) && $stable(sel_reg)) // RL9
        else $error("ratio changed after reset");
    a_active_exit: assert property (state_reg == PMCR_SMM && i_sys_mgmt_resume
        |=> o_sys_mgmt_active_n) // RL10
        else $error("active output held after exit");
    a_smm_no_stop: assert property (state_reg == PMCR_SMM // RL5
        |-> !o_core_halted && !o_grant_cycle)
        else $error("core stopped inside management mode");

    c_smm_entry: cover property ($rose(state_reg == PMCR_SMM));
    c_stop_grant: cover property ($rose(o_grant_cycle));
    c_smi_wake: cover property (state_reg == PMCR_STOP && smi_pend_reg);
    c_snoop_stop: cover property (state_reg == PMCR_STOP && o_snoop_ack);
    c_prio_defer: cover property (state_reg == PMCR_RUN && i_insn_boundary
        && stp_req && i_hi_prio_irq);

endmodule

// ---- dv/pmcr_pm_model.sv ----
`timescale 1ns/1ps
// ****************************************
// chipset power-management side
// ****************************************
module pmcr_pm_model (
    input  wire logic i_mclk,
    output logic      o_sys_mgmt_irq_n,
    output logic      o_stop_clock_req_n
);
    // both pins have pull-ups, so idle is high
    initial begin
        o_sys_mgmt_irq_n   = 1'b1;
        o_stop_clock_req_n = 1'b1;
    end

    // a single-clock pulse on purpose: the device has to latch it
    task automatic smi_pulse();
        @(posedge i_mclk);
        o_sys_mgmt_irq_n <= 1'b0;
        @(posedge i_mclk);
        o_sys_mgmt_irq_n <= 1'b1;
    endtask

    task automatic stop_req(input logic on);
        @(posedge i_mclk);
        o_stop_clock_req_n <= ~on;
    endtask
endmodule

// ---- dv/pmcr_top_test.sv ----
`timescale 1ns/1ps
module pmcr_top_test;
    import pmcr_pkg::*;
    logic        i_mclk  = 1'b0;
    logic        i_rstn  = 1'b0;
    logic        sel_hi  = 1'b1;
    logic        sel_lo  = 1'b1;
    logic        bnd     = 1'b0;
    logic        hi_prio = 1'b0;
    logic        resume  = 1'b0;
    logic        snoop   = 1'b0;
    wire logic   smi_n;
    wire logic   stp_n;
    logic        act_n;
    logic        halted;
    logic        grant;
    logic        snp_ack;
    logic [1:0]  bus_cyc;
    logic [1:0]  sel;
    pmcr_ratio_s ratio;
    int          miscompares = 0;
    int          n_checks    = 0;

    always #4 i_mclk = ~i_mclk;

    pmcr_pm_model pmcr_pm_model_i (.i_mclk(i_mclk), .o_sys_mgmt_irq_n(smi_n),
        .o_stop_clock_req_n(stp_n));
    pmcr_top pmcr_top_i (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_sys_mgmt_irq_n(smi_n),
        .i_stop_clock_req_n(stp_n), .i_bus_ratio_sel_hi(sel_hi), .i_bus_ratio_sel_lo(sel_lo),
        .i_insn_boundary(bnd), .i_hi_prio_irq(hi_prio), .i_sys_mgmt_resume(resume),
        .i_snoop_req(snoop), .o_sys_mgmt_active_n(act_n), .o_core_halted(halted),
        .o_grant_cycle(grant), .o_snoop_ack(snp_ack), .o_bus_cycle(bus_cyc),
        .o_ratio(ratio), .o_ratio_sel(sel));

    // ****************************************
    // helpers
    // ****************************************
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // outputs are sampled at the falling edge, away from the launching edge
    task automatic wait_sig(ref logic s, input logic v, input int n);
        @(negedge i_mclk);
        for (int k = 0; k < n && s !== v; k++) @(negedge i_mclk);
    endtask

    task automatic do_reset(input logic [1:0] code);
        @(posedge i_mclk);
        i_rstn <= 1'b0;
        {sel_hi, sel_lo} <= code;
        repeat (16) @(negedge i_mclk);
        check("active_n in reset", act_n, 1'b1);
        check("bus cycle in reset", {halted, grant, bus_cyc}, 8'h00);
        @(posedge i_mclk);
        i_rstn <= 1'b1;
        repeat (3) @(negedge i_mclk);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic test_ratio();
        logic [1:0] codes[4] = '{2'b00, 2'b10, 2'b11, 2'b01};
        logic [7:0] exp;
        logic [1:0] exp_sel;
        foreach (codes[k]) begin
            do_reset(codes[k]);
            // 01 is undefined and falls back to the default code
            exp_sel = (codes[k] == 2'b01) ? PMCR_RATIO_RST : codes[k];
            check("ratio sel", sel, exp_sel);
            case (codes[k])
                2'b00: exp = {PMCR_NUM_2_5, PMCR_DEN_2_5};
                2'b10: exp = {PMCR_NUM_1_2, PMCR_DEN_1_2};
                default: exp = {PMCR_NUM_2_3, PMCR_DEN_2_3};
            endcase
            check("ratio", ratio, exp);
            @(posedge i_mclk);
            {sel_hi, sel_lo} <= ~codes[k];
            repeat (6) @(negedge i_mclk);
            check("ratio held", ratio, exp);
            check("ratio sel held", sel, exp_sel);
        end
    endtask

    // a management request arriving while stopped wakes the core and wins over stop
    task automatic test_smi_wake();
        pmcr_pm_model_i.stop_req(1'b1);
        repeat (4) @(negedge i_mclk);
        @(posedge i_mclk);
        bnd <= 1'b1;
        wait_sig(halted, 1'b1, 4);
        check("halted before wake", halted, 1'b1);
        pmcr_pm_model_i.smi_pulse();
        wait_sig(act_n, 1'b0, 8);
        check("active_n after wake", act_n, 1'b0);
        check("halted after wake", halted, 1'b0);
        repeat (4) @(negedge i_mclk);
        check("stop ignored in mode", {halted, grant}, 8'h00);
        check("active_n stop pending", act_n, 1'b0);
        @(posedge i_mclk);
        bnd <= 1'b0;
        pmcr_pm_model_i.stop_req(1'b0);
        @(posedge i_mclk);
        resume <= 1'b1;
        @(posedge i_mclk);
        resume <= 1'b0;
        wait_sig(act_n, 1'b1, 2);
        check("active_n after wake resume", act_n, 1'b1);
        repeat (4) @(negedge i_mclk);
        check("no halt after wake resume", halted, 1'b0);
    endtask

    task automatic test_smm();
        pmcr_pm_model_i.smi_pulse();
        repeat (8) @(negedge i_mclk);
        check("active_n before boundary", act_n, 1'b1);
        @(posedge i_mclk);
        bnd <= 1'b1;
        wait_sig(act_n, 1'b0, 4);
        check("active_n at boundary", act_n, 1'b0);
        @(posedge i_mclk);
        bnd <= 1'b0;
        repeat (6) @(negedge i_mclk);
        check("active_n in mode", act_n, 1'b0);
        @(posedge i_mclk);
        resume <= 1'b1;
        @(posedge i_mclk);
        resume <= 1'b0;
        wait_sig(act_n, 1'b1, 2);
        check("active_n after resume", act_n, 1'b1);
    endtask

    task automatic test_stop();
        @(posedge i_mclk);
        bnd     <= 1'b1;
        hi_prio <= 1'b1;
        pmcr_pm_model_i.stop_req(1'b1);
        repeat (8) @(negedge i_mclk);
        check("halt deferred", {halted, grant}, 8'h00);
        @(posedge i_mclk);
        hi_prio <= 1'b0;
        wait_sig(grant, 1'b1, 4);
        check("grant cycle", {grant, bus_cyc}, {5'h00, 1'b1, PMCR_CYC_GRANT});
        check("halted", halted, 1'b1);
        @(negedge i_mclk);
        check("grant one clock", grant, 1'b0);
        @(posedge i_mclk);
        bnd   <= 1'b0;
        snoop <= 1'b1;
        @(posedge i_mclk);
        snoop <= 1'b0;
        @(negedge i_mclk);
        check("snoop while stopped", {snp_ack, bus_cyc}, {5'h00, 1'b1, PMCR_CYC_SNOOP});
        pmcr_pm_model_i.stop_req(1'b0);
        wait_sig(halted, 1'b0, 6);
        check("halt released", halted, 1'b0);
    endtask

    task automatic give_verdict();
        if (miscompares == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        test_ratio();
        test_smm();
        test_stop();
        test_smi_wake();
        give_verdict();
    end

    // the whole run is under two hundred clocks
    initial begin
        #100000;
        miscompares++;
        give_verdict();
    end
endmodule
